/* logic/filter_cfg_if.sv */
`timescale 1ns/1ps

interface filter_cfg_if;
    wake_filter_pkg::compare_sel_t compare_sel;
    wake_filter_pkg::length_code_t length_code;
    wake_filter_pkg::byte_t        payload7;
    logic                          config_valid;
    logic                          match;

    // The register side publishes settings and hears back about matches.
    modport cfg (output compare_sel, output length_code, output payload7,
                 output config_valid, input match);
    modport cmp (input compare_sel, input length_code, input payload7,
                 input config_valid, output match);
endinterface : filter_cfg_if

/* logic/frame_compare.sv */
`timescale 1ns/1ps
`include "wake_filter_consts.svh"

module frame_compare (
    // Clock and synchronised reset.
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // Settings from the register side.
    filter_cfg_if.cmp                      cfg,
    input  wire wake_filter_pkg::byte_t    compare_sel_top,
    input  wire wake_filter_pkg::frame_id_t expected_id,
    // Received frame, valid for one cycle.
    input  wire logic                      rx_frame_valid,
    input  wire logic                      rx_ide,
    input  wire wake_filter_pkg::frame_id_t rx_id,
    input  wire wake_filter_pkg::length_code_t rx_dlc,
    input  wire wake_filter_pkg::byte_t    rx_byte7
);

    wake_filter_pkg::frame_id_t full_sel;
    wake_filter_pkg::frame_id_t eff_sel;
    logic                       id_ok;
    logic                       dlc_ok;
    logic                       payload_ok;

    // A standard frame only has identifier positions 28 down to 18, so lower selects drop out.
    always_comb begin
        full_sel = {compare_sel_top, cfg.compare_sel};
        eff_sel  = rx_ide ? full_sel
                          : {full_sel[`WF_ID_MSB:`WF_STD_ID_LSB], `WF_EXT_ONLY_ZERO};
    end

    // A select of zero ignores a bit, a select of one demands equality.
    assign id_ok      = ((rx_id ^ expected_id) & eff_sel) == '0;
    // Length codes must agree bit for bit, even two codes that both mean eight bytes.
    assign dlc_ok     = (rx_dlc == cfg.length_code);
    // Byte seven only exists in a full-length payload.
    assign payload_ok = (wake_filter_pkg::payload_len(rx_dlc) != `WF_FULL_PAYLOAD)
                        || (rx_byte7 == cfg.payload7);

    // Match pulse; only a validated configuration may wake the chip.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg.match <= 1'b0;
        end else begin
            cfg.match <= rx_frame_valid && cfg.config_valid
                         && id_ok && dlc_ok && payload_ok;
        end
    end

    match_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.match |-> $past(rx_frame_valid) && $past(cfg.config_valid))
        else $error("Match raised without a frame or a valid configuration.");

    dlc_exact_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.match |-> $past(rx_dlc) == $past(cfg.length_code))
        else $error("Match raised with a differing length code.");

    std_id_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg.match |-> ((($past(rx_id) ^ $past(expected_id))
                        & $past(full_sel)) >> `WF_STD_ID_LSB) == '0)
        else $error("Match raised with a selected standard identifier bit differing.");

    full_payload_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.match && $past(rx_dlc) >= `WF_FULL_PAYLOAD) |-> $past(rx_byte7) == $past(cfg.payload7))
        else $error("Match raised with a differing payload byte seven.");

endmodule : frame_compare

/* logic/wake_filter_consts.svh */
`ifndef WAKE_FILTER_CONSTS_SVH
`define WAKE_FILTER_CONSTS_SVH

// Register offsets on the serial control port, seven address bits wide.
`define WF_ADDR_W            7
`define WF_OFF_SEL_MID       7'h28
`define WF_OFF_SEL_LOW       7'h29
`define WF_OFF_SEL_TAIL      7'h2a
`define WF_OFF_LENGTH_CODE   7'h2b
`define WF_OFF_PAYLOAD7      7'h2c

// Field positions inside the tail select byte and the length code byte.
`define WF_TAIL_MSB          6
`define WF_TAIL_LSB          2
`define WF_LEN_MSB           3
`define WF_LEN_RSVD_MSB      7
`define WF_LEN_RSVD_LSB      4

// Reset values and fixed figures.
`define WF_BYTE_RESET        8'h00
`define WF_LEN_RESET         4'h0
`define WF_SEL_RESET         21'h00000
`define WF_FULL_PAYLOAD      4'h8
`define WF_ID_MSB            28
`define WF_STD_ID_LSB        18
`define WF_EXT_ONLY_ZERO     18'h0000
`define WF_TAIL_RSVD_BIT     7

`endif

/* logic/wake_filter_pkg.sv */
`include "wake_filter_consts.svh"

package wake_filter_pkg;

    typedef logic [7:0]  byte_t;
    typedef logic [3:0]  length_code_t;
    typedef logic [20:0] compare_sel_t;
    typedef logic [28:0] frame_id_t;

    // Payload length in bytes for a four-bit length code; every code from eight up means eight.
    function automatic length_code_t payload_len(input length_code_t code);
        payload_len = code[`WF_LEN_MSB] ? `WF_FULL_PAYLOAD : code;
    endfunction : payload_len

endpackage : wake_filter_pkg

/* logic/wake_frame_filter_config.sv */
`timescale 1ns/1ps
`include "wake_filter_consts.svh"

module wake_frame_filter_config (
    // Clock and reset.
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // Register port of the serial control interface.
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [`WF_ADDR_W-1:0]         reg_addr,
    input  wire wake_filter_pkg::byte_t        reg_wdata,
    output logic [7:0]                         reg_rdata,
    // Chip mode and control events.
    input  wire logic                          stop_mode,
    input  wire logic                          restart_entry,
    input  wire logic                          soft_reset,
    input  wire logic                          cfg_valid_set,
    // Settings held outside this block.
    input  wire wake_filter_pkg::byte_t        compare_sel_top,
    input  wire wake_filter_pkg::frame_id_t    expected_id,
    // Received frame from the bus decoder.
    input  wire logic                          rx_frame_valid,
    input  wire logic                          rx_ide,
    input  wire wake_filter_pkg::frame_id_t    rx_id,
    input  wire wake_filter_pkg::length_code_t rx_dlc,
    input  wire wake_filter_pkg::byte_t        rx_byte7,
    // Results.
    output logic                               wake_up_frame,
    output logic                               filter_config_valid
);

    logic                          rst_meta;
    logic                          rst_n;
    wake_filter_pkg::byte_t        compare_sel_bits_20_13;
    wake_filter_pkg::byte_t        compare_sel_bits_12_5;
    logic [4:0]                    compare_sel_bits_4_0;
    wake_filter_pkg::length_code_t length_code;
    wake_filter_pkg::byte_t        expected_payload_byte7;
    wake_filter_pkg::byte_t        next_rdata;
    logic                          mapped;
    logic                          cfg_write;

    filter_cfg_if cfg_bus ();

    // Reset release passes two flip-flops so every register leaves reset on the same edge.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Address decode of the five registers this block owns.
    always_comb begin
        unique case (reg_addr)
            `WF_OFF_SEL_MID,
            `WF_OFF_SEL_LOW,
            `WF_OFF_SEL_TAIL,
            `WF_OFF_LENGTH_CODE,
            `WF_OFF_PAYLOAD7: mapped = 1'b1;
            default:          mapped = 1'b0;
        endcase
    end

    assign cfg_write = reg_wr && mapped;

    // Identifier compare selects; soft reset clears them like power-on does.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compare_sel_bits_20_13 <= `WF_BYTE_RESET;
            compare_sel_bits_12_5  <= `WF_BYTE_RESET;
            compare_sel_bits_4_0   <= '0;
        end else if (soft_reset) begin
            compare_sel_bits_20_13 <= `WF_BYTE_RESET;
            compare_sel_bits_12_5  <= `WF_BYTE_RESET;
            compare_sel_bits_4_0   <= '0;
        end else if (reg_wr) begin
            if (reg_addr == `WF_OFF_SEL_MID) begin
                compare_sel_bits_20_13 <= reg_wdata;
            end
            if (reg_addr == `WF_OFF_SEL_LOW) begin
                compare_sel_bits_12_5 <= reg_wdata;
            end
            if (reg_addr == `WF_OFF_SEL_TAIL) begin
                compare_sel_bits_4_0 <= reg_wdata[`WF_TAIL_MSB:`WF_TAIL_LSB];
            end
        end
    end

    // Length code: only four bits are stored, so the upper nibble can never hold a value.
    // Restart entry leaves the code alone; the reserved nibble is already zero.
    // Not storing the nibble at all means no restart path can ever leave it set.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            length_code <= `WF_LEN_RESET;
        end else if (soft_reset) begin
            length_code <= `WF_LEN_RESET;
        end else if (reg_wr && reg_addr == `WF_OFF_LENGTH_CODE) begin
            length_code <= reg_wdata[`WF_LEN_MSB:0];
        end
    end

    // Expected payload byte seven, a plain read-write byte.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            expected_payload_byte7 <= `WF_BYTE_RESET;
        end else if (soft_reset) begin
            expected_payload_byte7 <= `WF_BYTE_RESET;
        end else if (reg_wr && reg_addr == `WF_OFF_PAYLOAD7) begin
            expected_payload_byte7 <= reg_wdata;
        end
    end

    // Configuration valid: a set from the host wins over a clear in the same cycle, so a
    // validation written together with a change is not lost. A stop-mode write to any
    // register counts, since this block cannot tell CAN registers elsewhere apart.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filter_config_valid <= 1'b0;
        end else if (cfg_valid_set) begin
            filter_config_valid <= 1'b1;
        end else if (soft_reset || cfg_write || cfg_bus.match) begin
            filter_config_valid <= 1'b0;
        end else if (stop_mode && reg_wr) begin
            filter_config_valid <= 1'b0;
        end
    end

    // Read mux; reserved bits and unmapped addresses read as zero.
    always_comb begin
        next_rdata = '0;
        unique case (reg_addr)
            `WF_OFF_SEL_MID:     next_rdata = compare_sel_bits_20_13;
            `WF_OFF_SEL_LOW:     next_rdata = compare_sel_bits_12_5;
            `WF_OFF_SEL_TAIL:    next_rdata[`WF_TAIL_MSB:`WF_TAIL_LSB] = compare_sel_bits_4_0;
            `WF_OFF_LENGTH_CODE: next_rdata[`WF_LEN_MSB:0] = length_code;
            `WF_OFF_PAYLOAD7:    next_rdata = expected_payload_byte7;
            default:             next_rdata = '0;
        endcase
    end

    // Read data is registered one cycle after the read strobe and then held.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `WF_BYTE_RESET;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // Settings handed to the comparator.
    assign cfg_bus.compare_sel  = {compare_sel_bits_20_13, compare_sel_bits_12_5,
                                   compare_sel_bits_4_0};
    assign cfg_bus.length_code  = length_code;
    assign cfg_bus.payload7     = expected_payload_byte7;
    assign cfg_bus.config_valid = filter_config_valid;
    assign wake_up_frame        = cfg_bus.match;

    frame_compare u_compare (
        .clk             (clk),
        .rst_n           (rst_n),
        .cfg             (cfg_bus.cmp),
        .compare_sel_top (compare_sel_top),
        .expected_id     (expected_id),
        .rx_frame_valid  (rx_frame_valid),
        .rx_ide          (rx_ide),
        .rx_id           (rx_id),
        .rx_dlc          (rx_dlc),
        .rx_byte7        (rx_byte7)
    );

    len_rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `WF_OFF_LENGTH_CODE)
        |=> reg_rdata[`WF_LEN_RSVD_MSB:`WF_LEN_RSVD_LSB] == '0)
        else $error("Length code upper nibble read back non-zero.");

    tail_rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `WF_OFF_SEL_TAIL)
        |=> reg_rdata[`WF_TAIL_RSVD_BIT] == 1'b0 && reg_rdata[`WF_TAIL_LSB-1:0] == '0)
        else $error("Tail select reserved bits read back non-zero.");

    mid_write_back_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !soft_reset && reg_addr == `WF_OFF_SEL_MID)
        ##1 (!reg_wr && !soft_reset)
        ##1 (reg_rd && reg_addr == `WF_OFF_SEL_MID && !reg_wr && !soft_reset)
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("Mid select byte did not read back as written.");

    soft_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset |=> length_code == `WF_LEN_RESET && compare_sel_bits_20_13 == `WF_BYTE_RESET
                       && compare_sel_bits_12_5 == `WF_BYTE_RESET && compare_sel_bits_4_0 == '0)
        else $error("Soft reset left a setting non-zero.");

    restart_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (restart_entry && !reg_wr && !soft_reset) |=> $stable(length_code))
        else $error("Restart entry altered the length code.");

    payload_rw_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !soft_reset && reg_addr == `WF_OFF_PAYLOAD7)
        |=> expected_payload_byte7 == $past(reg_wdata))
        else $error("Payload byte seven not stored.");

    stop_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        (stop_mode && reg_wr && !cfg_valid_set) |=> !filter_config_valid)
        else $error("Stop-mode write left the configuration valid.");

    wake_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wake_up_frame && !cfg_valid_set) |=> !filter_config_valid)
        else $error("Wake-up left the configuration valid.");

    set_wins_a: assert property (@(posedge clk) disable iff (!rst_n)
        cfg_valid_set |=> filter_config_valid)
        else $error("Configuration valid set was lost.");

    // Each register stores exactly the bits written to it; soft reset beats a write
    // in the same cycle, so those cycles are left out of the store checks.
    sel_mid_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !soft_reset && reg_addr == `WF_OFF_SEL_MID)
        |=> compare_sel_bits_20_13 == $past(reg_wdata))
        else $error("Mid select byte not stored.");

    sel_low_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !soft_reset && reg_addr == `WF_OFF_SEL_LOW)
        |=> compare_sel_bits_12_5 == $past(reg_wdata))
        else $error("Low select byte not stored.");

    sel_tail_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !soft_reset && reg_addr == `WF_OFF_SEL_TAIL)
        |=> compare_sel_bits_4_0 == $past(reg_wdata[`WF_TAIL_MSB:`WF_TAIL_LSB]))
        else $error("Tail select bits not stored.");

    len_store_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !soft_reset && reg_addr == `WF_OFF_LENGTH_CODE)
        |=> length_code == $past(reg_wdata[`WF_LEN_MSB:0]))
        else $error("Length code not stored.");

    payload_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        soft_reset
        |=> expected_payload_byte7 == `WF_BYTE_RESET)
        else $error("Soft reset left payload byte seven non-zero.");

    // Read data must come from the addressed register as it stood at the read edge,
    // so a write in the same cycle is seen only by the next read.
    mid_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `WF_OFF_SEL_MID)
        |=> reg_rdata == $past(compare_sel_bits_20_13))
        else $error("Mid select byte read back wrong.");

    low_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `WF_OFF_SEL_LOW)
        |=> reg_rdata == $past(compare_sel_bits_12_5))
        else $error("Low select byte read back wrong.");

    tail_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `WF_OFF_SEL_TAIL)
        |=> reg_rdata[`WF_TAIL_MSB:`WF_TAIL_LSB] == $past(compare_sel_bits_4_0))
        else $error("Tail select bits read back wrong.");

    len_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `WF_OFF_LENGTH_CODE)
        |=> reg_rdata[`WF_LEN_MSB:0] == $past(length_code))
        else $error("Length code read back wrong.");

    payload_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_addr == `WF_OFF_PAYLOAD7)
        |=> reg_rdata == $past(expected_payload_byte7))
        else $error("Payload byte seven read back wrong.");

    // The valid flag rises only on a host set and falls on any change or soft reset;
    // writes elsewhere outside stop mode must leave it alone.
    valid_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(filter_config_valid)
        |-> $past(cfg_valid_set))
        else $error("Configuration valid rose without a host set.");

    cfg_change_a: assert property (@(posedge clk) disable iff (!rst_n)
        (cfg_write && !cfg_valid_set)
        |=> !filter_config_valid)
        else $error("Configuration change left the valid flag set.");

    soft_valid_a: assert property (@(posedge clk) disable iff (!rst_n)
        (soft_reset && !cfg_valid_set)
        |=> !filter_config_valid)
        else $error("Soft reset left the valid flag set.");

    idle_write_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
        (reg_wr && !stop_mode && !mapped && !soft_reset && !wake_up_frame && !cfg_valid_set)
        |=> filter_config_valid == $past(filter_config_valid))
        else $error("Unmapped write outside stop mode changed the valid flag.");

endmodule : wake_frame_filter_config

/* tb/can_frame_source.sv */
`timescale 1ns/1ps

module can_frame_source (
    // Clock of the receiving block.
    input  wire logic                           clk,
    // Decoded frame fields towards the filter.
    output logic                                rx_frame_valid,
    output logic                                rx_ide,
    output wake_filter_pkg::frame_id_t          rx_id,
    output wake_filter_pkg::length_code_t       rx_dlc,
    output wake_filter_pkg::byte_t              rx_byte7
);
    // Idle values at time zero, with no frame on offer.
    initial begin
        rx_frame_valid = 1'b0;
        rx_ide         = 1'b0;
        rx_id          = '0;
        rx_dlc         = 4'h0;
        rx_byte7       = 8'h00;
    end

    // Offers one decoded frame for a single cycle; a standard identifier sits in 28..18.
    task automatic send(input logic ide, input wake_filter_pkg::frame_id_t id,
                        input wake_filter_pkg::length_code_t dlc,
                        input wake_filter_pkg::byte_t b7);
        @(negedge clk);
        rx_frame_valid = 1'b1;
        rx_ide         = ide;
        rx_id          = id;
        rx_dlc         = dlc;
        rx_byte7       = b7;
        @(negedge clk);
        rx_frame_valid = 1'b0;
        // Stale fields are inverted so that a late sample cannot pass by luck.
        rx_ide         = ~ide;
        rx_id          = ~id;
        rx_dlc         = ~dlc;
        rx_byte7       = ~b7;
    endtask : send
endmodule : can_frame_source

/* tb/wake_frame_filter_config_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module wake_frame_filter_config_tb;
    localparam wake_filter_pkg::frame_id_t EXP_ID = 29'h1abcdef1;
    logic                          clk, reset_n, reg_wr, reg_rd, stop_mode;
    logic                          restart_entry, soft_reset, cfg_valid_set;
    logic [6:0]                    reg_addr;
    wake_filter_pkg::byte_t        reg_wdata, reg_rdata, rx_byte7, sel_top;
    logic                          rx_frame_valid, rx_ide, wake_up_frame, filter_config_valid;
    wake_filter_pkg::frame_id_t    rx_id;
    wake_filter_pkg::length_code_t rx_dlc;
    int                            n_errors = 0;
    int                            checked = 0;

    wake_frame_filter_config dut_u (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .stop_mode(stop_mode), .restart_entry(restart_entry), .soft_reset(soft_reset),
        .cfg_valid_set(cfg_valid_set), .compare_sel_top(sel_top), .expected_id(EXP_ID),
        .rx_frame_valid(rx_frame_valid), .rx_ide(rx_ide), .rx_id(rx_id), .rx_dlc(rx_dlc),
        .rx_byte7(rx_byte7), .wake_up_frame(wake_up_frame),
        .filter_config_valid(filter_config_valid));
    can_frame_source src_u (.clk(clk), .rx_frame_valid(rx_frame_valid), .rx_ide(rx_ide),
        .rx_id(rx_id), .rx_dlc(rx_dlc), .rx_byte7(rx_byte7));

    // Free-running 40 MHz clock.
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // One write strobe, driven at the falling edge and held over one rising edge.
    task automatic wr(input logic [6:0] a, input wake_filter_pkg::byte_t d);
        @(negedge clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr    = 1'b0;
    endtask : wr

    // One read strobe; data is registered at the taking edge and checked at the next falling edge.
    task automatic rd(input logic [6:0] a, input wake_filter_pkg::byte_t exp);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd   = 1'b0;
        `CHK("reg_rdata", exp, reg_rdata)
    endtask : rd

    // Single-cycle pulse on one control input.
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse

    // Arms the filter if asked, offers a frame and checks the one-cycle wake pulse.
    task automatic frame(input logic arm, input logic ide, input wake_filter_pkg::frame_id_t id,
                         input logic [3:0] dlc, input wake_filter_pkg::byte_t b7,
                         input logic exp);
        if (arm) pulse(cfg_valid_set);
        src_u.send(ide, id, dlc, b7);
        `CHK("wake_up_frame", exp, wake_up_frame)
        if (exp) begin
            @(negedge clk);
            `CHK("wake_up_frame", 1'b0, wake_up_frame)
            `CHK("filter_config_valid", 1'b0, filter_config_valid)
        end
    endtask : frame

    // Prints the counts and the verdict, then ends the run.
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict

    // Cuts a hang short; the whole sequence needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        {reg_wr, reg_rd, stop_mode, restart_entry, soft_reset, cfg_valid_set} = '0;
        reg_addr  = 7'h00;
        reg_wdata = 8'h00;
        sel_top   = 8'hff;
        reset_n   = 1'b0;
        repeat (8) @(posedge clk);
        @(negedge clk) reset_n = 1'b1;
        repeat (3) @(posedge clk);
        for (int a = 8'h28; a <= 8'h2c; a++) rd(a[6:0], 8'h00);
        `CHK("filter_config_valid", 1'b0, filter_config_valid)
        wr(7'h28, 8'ha5);
        rd(7'h28, 8'ha5);
        wr(7'h29, 8'h5a);
        rd(7'h29, 8'h5a);
        wr(7'h2a, 8'hff);
        rd(7'h2a, 8'h7c);
        wr(7'h2b, 8'hff);
        rd(7'h2b, 8'h0f);
        wr(7'h2c, 8'h3c);
        rd(7'h2c, 8'h3c);
        wr(7'h2d, 8'hff);
        rd(7'h2d, 8'h00);
        pulse(restart_entry);
        rd(7'h2b, 8'h0f);
        // Configuration-valid flag: set by host, cleared by changes and stop-mode writes.
        pulse(cfg_valid_set);
        `CHK("filter_config_valid", 1'b1, filter_config_valid)
        wr(7'h30, 8'h11);
        `CHK("filter_config_valid", 1'b1, filter_config_valid)
        stop_mode = 1'b1;
        wr(7'h30, 8'h11);
        `CHK("filter_config_valid", 1'b0, filter_config_valid)
        stop_mode = 1'b0;
        pulse(cfg_valid_set);
        wr(7'h28, 8'hff);
        `CHK("filter_config_valid", 1'b0, filter_config_valid)
        wr(7'h29, 8'h00);
        // Selects: 28..13 and 4..0 compared, 12..5 ignored; length code fifteen.
        frame(1'b0, 1'b1, EXP_ID, 4'hf, 8'h3c, 1'b0);
        frame(1'b1, 1'b1, EXP_ID, 4'hf, 8'h3c, 1'b1);
        frame(1'b1, 1'b1, EXP_ID ^ 29'h20, 4'hf, 8'h3c, 1'b1);
        frame(1'b1, 1'b1, EXP_ID ^ 29'h1, 4'hf, 8'h3c, 1'b0);
        frame(1'b0, 1'b1, EXP_ID ^ 29'h2000, 4'hf, 8'h3c, 1'b0);
        frame(1'b0, 1'b1, EXP_ID ^ 29'h10000000, 4'hf, 8'h3c, 1'b0);
        frame(1'b0, 1'b1, EXP_ID, 4'h8, 8'h3c, 1'b0);
        frame(1'b0, 1'b1, EXP_ID, 4'hf, 8'hc3, 1'b0);
        frame(1'b0, 1'b0, EXP_ID ^ 29'h1, 4'hf, 8'h3c, 1'b1);
        frame(1'b1, 1'b0, EXP_ID ^ 29'h40000, 4'hf, 8'h3c, 1'b0);
        // With the top select for identifier bit 28 off, a difference there is ignored.
        sel_top = 8'h7f;
        frame(1'b1, 1'b1, EXP_ID ^ 29'h10000000, 4'hf, 8'h3c, 1'b1);
        sel_top = 8'hff;
        wr(7'h2b, 8'h05);
        frame(1'b1, 1'b1, EXP_ID, 4'h5, 8'hc3, 1'b1);
        // Soft reset wipes every setting and the valid flag.
        pulse(cfg_valid_set);
        pulse(soft_reset);
        `CHK("filter_config_valid", 1'b0, filter_config_valid)
        for (int a = 8'h28; a <= 8'h2c; a++) rd(a[6:0], 8'h00);
        give_verdict();
    end
endmodule : wake_frame_filter_config_tb
